// File: bench/bpc_board.sv
// Board model: a key per pin, weak pull-ups, released lines that wobble
`timescale 1ns/1ps
module bpc_board (
    // Clock
    input wire logic hclk,
    // Port side
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pullup_on,
    // Keys
    input wire logic [7:0] key_on,
    input wire logic [7:0] key_lvl,
    // Resolved pin level
    output logic [7:0] pin_lvl
);
    logic [7:0] wob = 8'h55;
    // A line nobody holds must not read as a stable value
    always @(posedge hclk) wob <= ~wob;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe[i]) pin_lvl[i] = pin_out[i];
            else if (key_on[i]) pin_lvl[i] = key_lvl[i];
            else if (pullup_on[i]) pin_lvl[i] = 1'b1;
            else pin_lvl[i] = wob[i];
        end
    end
endmodule

// File: bench/tb_bpc_port.sv
// Self-checking bench for the change-detect port
`timescale 1ns/1ps
module tb_bpc_port;
    import bpc_pkg::*;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, mv = 1'b0;
    logic route = 1'b0, ccp_out = 1'b0, ccp_drv = 1'b0, sd = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic hready, hreadyout, hresp, pfault, chg, wake;
    logic [7:0] pin_in, pin_out, pin_oe, pu_on, key_on = 8'hFF, key_lvl = 8'h00;
    logic [3:0] ext_irq;
    logic cap;
    int err_count = 0;
    int n_checks = 0;
    always #4 hclk = ~hclk;
    assign hready = hreadyout;
    bpc_port i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .pullup_on(pu_on), .reg_to_reg_move(mv),
        .ccp_route_mode(route), .ccp_out(ccp_out), .ccp_drive(ccp_drv), .pwm_shutdown(sd),
        .ccp_capture_in(cap), .ext_irq_in(ext_irq), .pwm_fault_in(pfault),
        .change_irq(chg), .wake_req(wake));
    bpc_board i_board (.hclk(hclk), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_on(pu_on),
        .key_on(key_on), .key_lvl(key_lvl), .pin_lvl(pin_in));
    task report_and_stop;
        if (err_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task edge_ready;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 20) begin
                err_count++;
                report_and_stop;
            end
            @(posedge hclk);
        end
    endtask
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic m);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        edge_ready;
        htrans <= 2'h0;
        hwdata <= d;
        mv <= m;
        edge_ready;
        rd = hrdata;
        mv <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 1'b0);
    endtask
    // Idle cycle first: a read right behind a write to it sees the old value
    task rdc(input logic [7:0] a, input logic [31:0] e);
        @(posedge hclk);
        xfer(1'b0, a, 32'h0, 1'b0);
        chk(rd, e);
    endtask
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(negedge hclk);
        chk(pu_on, 8'h00);
        chk(pin_oe, 8'h00);
        @(posedge hclk);
        rdc(OFS_DIR, 32'hFF);
        rdc(OFS_CTRL_TWO, 32'h80);
        rdc(8'h40, 32'h0);
        chk(hresp, HRESP_OKAY);
        wr(OFS_DIR, 32'hCF);
        wr(OFS_PORT, 32'hA5);
        wr(OFS_CTRL_TWO, 32'h0);
        wr(OFS_ALT, 32'h3);
        rdc(OFS_LAT, 32'hA5);
        rdc(OFS_PORT, 32'h20);
        key_lvl <= 8'h2F;
        @(negedge hclk);
        chk({pin_oe, pin_out & 8'h30}, 16'h3020);
        chk(pu_on, 8'hCF);
        chk({ext_irq, pfault}, 5'h1F);
        @(posedge hclk);
        rdc(OFS_CTRL_MAIN, 32'h0);
        key_lvl <= 8'hAF;
        repeat (3) @(posedge hclk);
        wr(OFS_CTRL_MAIN, 32'h8);
        rdc(OFS_CTRL_MAIN, 32'h9);
        @(negedge hclk);
        chk({chg, wake}, 2'h3);
        @(posedge hclk);
        xfer(1'b1, OFS_PORT, 32'hA5, 1'b1);
        wr(OFS_CTRL_MAIN, 32'h8);
        rdc(OFS_CTRL_MAIN, 32'h9);
        rdc(OFS_PORT, 32'hAF);
        wr(OFS_CTRL_MAIN, 32'h8);
        rdc(OFS_CTRL_MAIN, 32'h8);
        key_lvl <= 8'hEF;
        repeat (3) @(posedge hclk);
        wr(OFS_PORT, 32'hA5);
        wr(OFS_CTRL_MAIN, 32'h8);
        rdc(OFS_CTRL_MAIN, 32'h8);
        route <= 1'b1;
        wr(OFS_DIR, 32'hC7);
        wr(OFS_ALT, 32'h4);
        ccp_drv <= 1'b1;
        ccp_out <= 1'b1;
        @(negedge hclk);
        chk({pin_out[3], pin_oe[3], ext_irq, cap}, 7'h6E);
        @(posedge hclk);
        sd <= 1'b1;
        @(negedge hclk);
        chk(pin_oe[3], 1'b0);
        @(posedge hclk);
        hresetn <= 1'b0;
        @(negedge hclk);
        chk(pu_on, 8'h00);
        report_and_stop;
    end
endmodule

// File: design/bpc_pkg.sv
// Constants, register map and state type of the bidirectional change-detect port
package bpc_pkg;
    localparam int PIN_W = 8;

    localparam logic [7:0] OFS_PORT = 8'h00;
    localparam logic [7:0] OFS_DIR = 8'h04;
    localparam logic [7:0] OFS_LAT = 8'h08;
    localparam logic [7:0] OFS_CTRL_MAIN = 8'h0C;
    localparam logic [7:0] OFS_CTRL_TWO = 8'h10;
    localparam logic [7:0] OFS_ALT = 8'h14;

    localparam int BIT_FLAG = 0;
    localparam int BIT_IRQ_EN = 3;
    localparam int BIT_PU_N = 7;
    localparam int BIT_ALT_SEL = 0;
    localparam int BIT_FLT_EN = 1;
    localparam int BIT_SD_TRI = 2;

    localparam int CCP_PIN = 3;
    localparam logic [7:0] CHANGE_MASK = 8'hF0;
    localparam logic [7:0] EXT_IRQ_MASK = 8'h0F;

    localparam logic [7:0] RST_DIR = 8'hFF;
    localparam logic [7:0] RST_LAT = 8'h00;
    localparam logic RST_PU_N = 1'b1;
    localparam logic RST_ALT_SEL = 1'b1;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
    localparam logic HRESP_OKAY = 1'b0;

    typedef struct packed {
        logic [7:0] dir;
        logic [7:0] lat;
        logic [3:0] snap;
        logic flag;
        logic irq_en;
        logic pu_n;
        logic alt_sel;
        logic flt_en;
        logic sd_tri;
        logic ph_write;
        logic [7:0] ph_addr;
        logic [31:0] rdata;
    } bpc_state_t;

    localparam bpc_state_t RST_STATE = '{
        dir: RST_DIR, lat: RST_LAT, snap: 4'h0, flag: 1'b0, irq_en: 1'b0,
        pu_n: RST_PU_N, alt_sel: RST_ALT_SEL, flt_en: 1'b0, sd_tri: 1'b0,
        ph_write: 1'b0, ph_addr: 8'h00, rdata: 32'h0000_0000};
endpackage

// File: design/bpc_port.sv
// Eight-pin bidirectional port with change detection, pull-ups and AHB-Lite registers
//
// Added by the designer: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
module bpc_port
    import bpc_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Pins
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe,
    output logic [7:0] pullup_on,
    // Core qualifiers
    input wire logic reg_to_reg_move,
    input wire logic ccp_route_mode,
    // Second capture/compare/PWM module
    input wire logic ccp_out,
    input wire logic ccp_drive,
    input wire logic pwm_shutdown,
    output logic ccp_capture_in,
    // Interrupt and peripheral feeds
    output logic [3:0] ext_irq_in,
    output logic pwm_fault_in,
    output logic change_irq,
    output logic wake_req
);
    bpc_state_t st;
    bpc_state_t next_st;
    logic take;
    logic ph_valid;
    logic mapped;
    logic mismatch;
    logic routed;
    logic [7:0] rd_val;
    logic port_acc;

    // Only whole-word accesses are mapped; any other hsize reads zero and writes nothing
    assign take = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
    assign mapped = (haddr[31:8] == 24'h00_0000) && (haddr[1:0] == 2'h0) && (hsize == 3'h2);

    // Output-configured pins are masked out so their own drive cannot trip the flag
    assign mismatch = |(((pin_in[7:4] ^ st.snap) & st.dir[7:4]));
    assign routed = ccp_route_mode && !st.alt_sel;

    always_comb begin
        unique case (haddr[7:0])
            OFS_PORT: rd_val = pin_in;
            OFS_DIR: rd_val = st.dir;
            OFS_LAT: rd_val = st.lat;
            OFS_CTRL_MAIN: rd_val = {4'h0, st.irq_en, 2'h0, st.flag};
            OFS_CTRL_TWO: rd_val = {st.pu_n, 7'h00};
            OFS_ALT: rd_val = {5'h00, st.sd_tri, st.flt_en, st.alt_sel};
            default: rd_val = 8'h00;
        endcase
    end

    // Port accessed: read in its address phase, write in its data phase unless reg_to_reg_move is high
    always_comb begin
        port_acc = take && !hwrite && mapped && haddr[7:0] == OFS_PORT;
        if (ph_valid && st.ph_write && st.ph_addr == OFS_PORT && !reg_to_reg_move) begin
            port_acc = 1'b1;
        end
    end

    always_comb begin
        next_st = st;
        next_st.ph_write = take && hwrite && mapped;
        next_st.ph_addr = haddr[7:0];
        if (take && !hwrite) begin
            next_st.rdata = mapped ? {24'h00_0000, rd_val} : 32'h0000_0000;
        end
        if (port_acc) begin
            next_st.snap = pin_in[7:4];
        end
        if (ph_valid && st.ph_write) begin
            unique case (st.ph_addr)
                OFS_PORT: next_st.lat = hwdata[7:0];
                OFS_DIR: next_st.dir = hwdata[7:0];
                OFS_LAT: next_st.lat = hwdata[7:0];
                OFS_CTRL_MAIN: begin
                    next_st.flag = hwdata[BIT_FLAG];
                    next_st.irq_en = hwdata[BIT_IRQ_EN];
                end
                OFS_CTRL_TWO: next_st.pu_n = hwdata[BIT_PU_N];
                OFS_ALT: begin
                    next_st.alt_sel = hwdata[BIT_ALT_SEL];
                    next_st.flt_en = hwdata[BIT_FLT_EN];
                    next_st.sd_tri = hwdata[BIT_SD_TRI];
                end
                default: next_st.flag = st.flag;
            endcase
        end
        // Set beats a clear in the same cycle
        if (mismatch) begin
            next_st.flag = 1'b1;
        end
    end

    assign ph_valid = st.ph_write;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= RST_STATE;
        end else begin
            st <= next_st;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = HRESP_OKAY;
    assign hrdata = st.rdata;

    genvar i;
    generate
        for (i = 0; i < PIN_W; i++) begin : g_pin
            if (i == CCP_PIN) begin : g_ccp
                // Module output wins over latch; tri-state on shutdown when enabled
                assign pin_out[i] = (routed && ccp_drive) ? ccp_out : st.lat[i];
                assign pin_oe[i] = !st.dir[i] && !(routed && st.sd_tri && pwm_shutdown);
            end else begin : g_std
                assign pin_out[i] = st.lat[i];
                assign pin_oe[i] = !st.dir[i];
            end
            assign pullup_on[i] = !st.pu_n && st.dir[i];
        end
    endgenerate

    assign ext_irq_in = pin_in[3:0] & st.dir[3:0];
    assign pwm_fault_in = pin_in[0] && st.dir[0] && st.flt_en;
    assign ccp_capture_in = pin_in[CCP_PIN] && routed && st.dir[CCP_PIN];
    assign change_irq = st.flag && st.irq_en;
    assign wake_req = change_irq;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_DIR_HIZ: assert property ((st.dir == 8'hFF) |-> (pin_oe == 8'h00))
        else $error("input pins are driven");
    AST_DRIVE_LATCH: assert property (((pin_out ^ st.lat) & ~st.dir & 8'hF7) == 8'h00)
        else $error("output pin differs from latch");
    AST_LATCH_READ: assert property ((take && !hwrite && mapped && haddr[7:0] == OFS_LAT
        && !(ph_valid && st.ph_addr == OFS_LAT)) |=> (hrdata[7:0] == $past(st.lat)))
        else $error("latch read returned wrong value");
    AST_PU_OUT_OFF: assert property ((pullup_on & ~st.dir) == 8'h00)
        else $error("pull-up on an output pin");
    AST_PU_CTRL: assert property ((pullup_on != 8'h00) |-> !st.pu_n)
        else $error("pull-up on while disabled");
    AST_EXCLUDE_OUT: assert property ((st.dir[7:4] == 4'h0) |-> !mismatch)
        else $error("output pin caused mismatch");
    AST_MISMATCH_SETS: assert property (mismatch |=> st.flag)
        else $error("flag not set by mismatch");
    AST_SNAP_REFRESH: assert property ((take && !hwrite && mapped && haddr[7:0] == OFS_PORT)
        |=> (st.snap == $past(pin_in[7:4])))
        else $error("snapshot not refreshed on port read");
    AST_CCP_PRI: assert property ((routed && ccp_drive && !st.dir[CCP_PIN] && !pwm_shutdown)
        |-> (pin_out[CCP_PIN] == ccp_out && pin_oe[CCP_PIN]))
        else $error("ccp output lost priority");
    AST_PWM_TRI: assert property ((routed && st.sd_tri && pwm_shutdown) |-> !pin_oe[CCP_PIN])
        else $error("pin 3 driven during shutdown");
    AST_IRQ_GATE: assert property ((!st.irq_en) |-> (!change_irq && !wake_req))
        else $error("interrupt raised while disabled");
endmodule
